//--- rtl/byte_alu_instruction_subset.sv
// Purpose: execution datapath for a small byte instruction subset
// Assumes: AHB-Lite single word transfers, one slave on the bus
// Notes:   a command write stalls one cycle while the file operand is read
module byte_alu_instruction_subset (
  // clock and reset
  input  wire logic                             hclk,
  input  wire logic                             hresetn,
  // ahb-lite slave
  input  wire logic                             hsel,
  input  wire logic [byte_alu_pkg::BUS_W-1:0]   haddr,
  input  wire logic [1:0]                       htrans,
  input  wire logic                             hwrite,
  input  wire logic [2:0]                       hsize,
  input  wire logic [byte_alu_pkg::BUS_W-1:0]   hwdata,
  input  wire logic                             hready,
  output logic      [byte_alu_pkg::BUS_W-1:0]   hrdata,
  output logic                                  hreadyout,
  output logic      [1:0]                       hresp,
  // port direction outputs
  output logic      [byte_alu_pkg::DATA_W-1:0]  port_a_direction,
  output logic      [byte_alu_pkg::DATA_W-1:0]  port_b_direction,
  output logic      [byte_alu_pkg::DATA_W-1:0]  port_c_direction,
  // core state
  output logic      [byte_alu_pkg::DATA_W-1:0]  work_reg,
  output logic                                  carry_flag,
  output logic                                  nibble_carry_flag,
  output logic                                  zero_flag
);
  import byte_alu_pkg::*;

  typedef enum logic [1:0] {S_IDLE, S_EXEC, S_FRD} state_type;

  state_type            state_r;
  logic                 dph_valid_r;
  logic                 dph_write_r;
  logic [OFF_W-1:0]     dph_addr_r;
  logic [BUS_W-1:0]     cmd_r;
  logic [DATA_W-1:0]    w_r;
  logic                 c_r;
  logic                 dc_r;
  logic                 z_r;
  logic                 err_r;
  logic [DATA_W-1:0]    dir_r [0:NUM_DIR-1];
  logic [BUS_W-1:0]     hrdata_r;

  // file window decode, used for both bus phases
  function automatic logic is_file(input logic [OFF_W-1:0] a);
    return a[OFF_W-1:9] == OFF_FILE[OFF_W-1:9];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bus phase decode
  wire              accept   = hsel & hready & htrans[1];
  wire [OFF_W-1:0]  a_off    = haddr[OFF_W-1:0];
  wire              a_file   = is_file(a_off);
  wire              idle     = state_r == S_IDLE;
  wire              dp_wr    = dph_valid_r & dph_write_r & idle;
  wire              cmd_wr   = dp_wr & (dph_addr_r == OFF_CMD);
  wire              bus_wr   = dp_wr & ~cmd_wr;
  wire              wr_work  = bus_wr & (dph_addr_r == OFF_WORK);
  wire              wr_stat  = bus_wr & (dph_addr_r == OFF_STATUS);
  wire              wr_file  = bus_wr & is_file(dph_addr_r);
  wire              rd_file  = accept & ~hwrite & a_file;
  wire              rd_reg   = accept & ~hwrite & ~a_file;

  // stall during the operand fetch and during a file read; the execute
  // cycle ends the command's data phase, so the command is not taken twice
  assign hreadyout = (idle & ~cmd_wr) | (state_r == S_EXEC);
  assign hresp     = HRESP_OKAY;
  assign hrdata    = hrdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // command fields, valid in the execute cycle
  wire [OP_W-1:0]    op      = cmd_r[CMD_OP_LSB +: OP_W];
  wire [FADDR_W-1:0] f_addr  = cmd_r[CMD_F_LSB +: FADDR_W];
  wire               d_bit   = cmd_r[CMD_D_BIT];
  wire [DATA_W-1:0]  k_lit   = cmd_r[CMD_K_LSB +: DATA_W];
  wire               exec    = state_r == S_EXEC;
  wire [DATA_W-1:0]  fval;

  // operation decode
  wire is_sub  = op == OP_SUB_BORROW;
  wire is_swap = op == OP_NIB_SWAP;
  wire is_xi   = op == OP_XOR_IMM;
  wire is_xf   = op == OP_XOR_FILE;
  wire is_dir  = op == OP_DIR_LOAD;
  wire dir_ok  = (f_addr >= DIR_SEL_A) & (f_addr <= DIR_SEL_C); // RULE_07
  wire has_dst = is_sub | is_swap | is_xf;
  wire op_ok   = has_dst | is_xi | (is_dir & dir_ok);            // RULE_07

  ////////////////////////////////////////////////////////////////////////////
  // arithmetic: f + ~w + c is f - w - borrow
  wire [DATA_W:0] sub_sum = {1'b0, fval} + {1'b0, ~w_r}
                          + {{DATA_W{1'b0}}, c_r};               // RULE_01
  wire [4:0]      lo_sum  = {1'b0, fval[3:0]} + {1'b0, ~w_r[3:0]}
                          + {4'h0, c_r};                         // RULE_01
  wire [DATA_W-1:0] swap_res = {fval[3:0], fval[7:4]};           // RULE_03
  wire [DATA_W-1:0] xi_res   = w_r ^ k_lit;                      // RULE_04
  wire [DATA_W-1:0] xf_res   = w_r ^ fval;                       // RULE_05

  // result selection
  wire [DATA_W-1:0] result = is_sub  ? sub_sum[DATA_W-1:0] :
                             is_swap ? swap_res :
                             is_xi   ? xi_res : xf_res;

  // destination steering
  wire go      = exec & op_ok;
  wire to_work = go & (is_xi | (has_dst & ~d_bit));              // RULE_02
  wire to_file = go & has_dst & d_bit;                           // RULE_02
  wire upd_z   = go & (is_sub | is_xi | is_xf);                  // RULE_08
  wire upd_cdc = go & is_sub;                                    // RULE_01
  wire res_z   = result == '0;                                   // RULE_08

  ////////////////////////////////////////////////////////////////////////////
  // file memory ports
  wire [FADDR_W-1:0] mem_raddr = cmd_wr ? hwdata[CMD_F_LSB +: FADDR_W]
                                        : haddr[FADDR_W+1:2];
  wire               mem_we    = to_file | wr_file;
  wire [FADDR_W-1:0] mem_waddr = exec ? f_addr : dph_addr_r[FADDR_W+1:2];
  wire [DATA_W-1:0]  mem_wdata = exec ? result : hwdata[DATA_W-1:0];

  file_reg_mem #(
    .WIDTH (DATA_W),
    .DEPTH (FDEPTH),
    .AW    (FADDR_W)
  ) u_file_mem (
    .hclk    (hclk),
    .hresetn (hresetn),
    .we      (mem_we),
    .waddr   (mem_waddr),
    .wdata   (mem_wdata),
    .raddr   (mem_raddr),
    .rdata   (fval)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register read mux for the address phase
  wire [BUS_W-1:0] stat_word = {{(BUS_W-4){1'b0}}, err_r, z_r, dc_r, c_r};
  wire [BUS_W-1:0] rd_mux =
    (a_off == OFF_WORK)   ? {{(BUS_W-DATA_W){1'b0}}, w_r} :
    (a_off == OFF_STATUS) ? stat_word :
    (a_off == OFF_DIR_A)  ? {{(BUS_W-DATA_W){1'b0}}, dir_r[0]} :
    (a_off == OFF_DIR_B)  ? {{(BUS_W-DATA_W){1'b0}}, dir_r[1]} :
    (a_off == OFF_DIR_C)  ? {{(BUS_W-DATA_W){1'b0}}, dir_r[2]} :
    '0;

  ////////////////////////////////////////////////////////////////////////////
  // bus data phase tracking
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_valid_r <= 1'b0;
      dph_write_r <= 1'b0;
      dph_addr_r  <= '0;
    end else if (hready) begin
      dph_valid_r <= accept;
      dph_write_r <= hwrite;
      dph_addr_r  <= a_off;
    end
  end

  // sequencer: idle, execute, file read wait
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= S_IDLE;
      cmd_r   <= '0;
    end else begin
      case (state_r)
        S_IDLE: begin
          if (cmd_wr) begin
            state_r <= S_EXEC;
            cmd_r   <= hwdata;
          end else if (rd_file) begin
            state_r <= S_FRD;
          end
        end
        S_EXEC: begin
          // a file read may be taken while the command executes
          if (rd_file) begin
            state_r <= S_FRD;
          end else begin
            state_r <= S_IDLE;
          end
        end
        S_FRD:  state_r <= S_IDLE;
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // read data register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= '0;
    end else if (state_r == S_FRD) begin
      hrdata_r <= {{(BUS_W-DATA_W){1'b0}}, fval};
    end else if (rd_reg) begin
      hrdata_r <= rd_mux;
    end
  end

  // working register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      w_r <= WORK_RESET;
    end else if (to_work) begin
      w_r <= result;                                             // RULE_02
    end else if (wr_work) begin
      w_r <= hwdata[DATA_W-1:0];
    end
  end

  // flags; a nibble exchange never reaches them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      c_r   <= 1'b0;
      dc_r  <= 1'b0;
      z_r   <= 1'b0;
      err_r <= 1'b0;
    end else begin
      if (upd_cdc) begin
        c_r  <= sub_sum[DATA_W];                                 // RULE_01
        dc_r <= lo_sum[4];                                       // RULE_01
      end else if (wr_stat) begin
        c_r  <= hwdata[ST_C];
        dc_r <= hwdata[ST_DC];
      end
      if (upd_z) begin
        z_r <= res_z;                                            // RULE_08
      end else if (wr_stat) begin
        z_r <= hwdata[ST_Z];
      end
      if (exec & ~op_ok) begin
        err_r <= 1'b1;                                           // RULE_07
      end else if (wr_stat & hwdata[ST_ERR]) begin
        err_r <= 1'b0;
      end
    end
  end

  // direction registers, one per port
  genvar gi;
  generate
    for (gi = 0; gi < NUM_DIR; gi++) begin : g_dir
      wire [FADDR_W-1:0] sel = DIR_SEL_A + FADDR_W'(gi);
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          dir_r[gi] <= DIR_RESET;
        end else if (go & is_dir & (f_addr == sel)) begin
          dir_r[gi] <= w_r;                                      // RULE_06
        end
      end
    end
  endgenerate

  // core state outputs
  assign port_a_direction  = dir_r[0];
  assign port_b_direction  = dir_r[1];
  assign port_c_direction  = dir_r[2];
  assign work_reg          = w_r;
  assign carry_flag        = c_r;
  assign nibble_carry_flag = dc_r;
  assign zero_flag         = z_r;

endmodule

//--- inc/byte_alu_pkg.sv
// Purpose: constants shared by the byte alu datapath and its file memory
// Assumes: one hclk domain, AHB-Lite register access, word transfers only
// Notes:   offsets are byte addresses on haddr[11:0]
//
// Summary of operation
// RULE_01: subtract with borrow gives file minus working minus inverted carry and updates carry, nibble carry and zero.
// RULE_02: a destination bit of 0 sends the result to the working register, 1 sends it back to the file register.
// RULE_03: nibble exchange swaps the low and high halves of the file value and leaves every flag alone.
// RULE_04: xor immediate combines the working register with an 8-bit literal, writes the working register and touches only zero.
// RULE_05: xor file combines the working register with the file value, writes the chosen destination and touches only zero.
// RULE_06: direction load copies the working register to port A, B or C direction for operand 5, 6 or 7.
// RULE_07: direction load takes only operands 5 to 7; any other operand is refused and loads nothing.
// RULE_08: zero is set when a result that updates it is all zero and cleared otherwise.
package byte_alu_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int DATA_W  = 8;
  localparam int BUS_W   = 32;
  localparam int FADDR_W = 7;
  localparam int FDEPTH  = 128;
  localparam int OFF_W   = 12;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [OFF_W-1:0] OFF_CMD    = 12'h000;
  localparam logic [OFF_W-1:0] OFF_WORK   = 12'h004;
  localparam logic [OFF_W-1:0] OFF_STATUS = 12'h008;
  localparam logic [OFF_W-1:0] OFF_DIR_A  = 12'h00C;
  localparam logic [OFF_W-1:0] OFF_DIR_B  = 12'h010;
  localparam logic [OFF_W-1:0] OFF_DIR_C  = 12'h014;
  localparam logic [OFF_W-1:0] OFF_FILE   = 12'h200;

  ////////////////////////////////////////////////////////////////////////////
  // command word fields
  localparam int CMD_K_LSB  = 0;
  localparam int CMD_F_LSB  = 8;
  localparam int CMD_D_BIT  = 15;
  localparam int CMD_OP_LSB = 16;
  localparam int OP_W       = 3;

  // operation codes
  localparam logic [OP_W-1:0] OP_SUB_BORROW = 3'h0;
  localparam logic [OP_W-1:0] OP_NIB_SWAP   = 3'h1;
  localparam logic [OP_W-1:0] OP_XOR_IMM    = 3'h2;
  localparam logic [OP_W-1:0] OP_XOR_FILE   = 3'h3;
  localparam logic [OP_W-1:0] OP_DIR_LOAD   = 3'h4;

  // direction load operand range
  localparam logic [FADDR_W-1:0] DIR_SEL_A = 7'h05;
  localparam logic [FADDR_W-1:0] DIR_SEL_C = 7'h07;
  localparam int                 NUM_DIR   = 3;

  ////////////////////////////////////////////////////////////////////////////
  // status bits and reset values
  localparam int ST_C   = 0;
  localparam int ST_DC  = 1;
  localparam int ST_Z   = 2;
  localparam int ST_ERR = 3;

  localparam logic [DATA_W-1:0] DIR_RESET  = 8'hFF;
  localparam logic [DATA_W-1:0] WORK_RESET = 8'h00;
  localparam logic [1:0]        HRESP_OKAY = 2'h0;

endpackage

//--- rtl/file_reg_mem.sv
// Purpose: file register storage with registered read data
// Assumes: one write and one read port on hclk
// Notes:   read data appear one edge after the read address
module file_reg_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 128,
  parameter int AW    = 7
) (
  // clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // write port
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  // read port
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem_r [0:DEPTH-1];
  logic [WIDTH-1:0] rdata_r;

  // storage write, no reset on the array
  always_ff @(posedge hclk) begin
    if (we) begin
      mem_r[waddr] <= wdata;
    end
  end

  // registered read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= mem_r[raddr];
    end
  end

  assign rdata = rdata_r;

endmodule

//--- verification/alu_bus_monitor.sv
// Purpose: bus timing and output moment checks for the byte alu
// Assumes: one slave, hready tied to hreadyout
// Notes:   sees only the top ports
module alu_bus_monitor
  import byte_alu_pkg::*;
(
  // clock and reset
  input wire logic             hclk,
  input wire logic             hresetn,
  // ahb-lite slave
  input wire logic             hsel,
  input wire logic [BUS_W-1:0] haddr,
  input wire logic [1:0]       htrans,
  input wire logic             hwrite,
  input wire logic             hready,
  input wire logic [BUS_W-1:0] hrdata,
  input wire logic             hreadyout,
  input wire logic [1:0]       hresp,
  // core outputs
  input wire logic [7:0]       port_a_direction,
  input wire logic [7:0]       port_b_direction,
  input wire logic [7:0]       port_c_direction,
  input wire logic [7:0]       work_reg
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // an address phase accepted by the slave
  wire tk = hsel & hready & htrans[1];
  wire [11:0] a = haddr[11:0];

  ////////////////////////////////////////////////////////////////////////////
  // bus answers
  chk_resp_okay: assert property (hresp == HRESP_OKAY)
    else $error("response not okay");
  chk_wait_single: assert property (!hreadyout |=> hreadyout)
    else $error("wait longer than one cycle");
  chk_cmd_wait: assert property (tk && hwrite && a == OFF_CMD
    |=> !hreadyout ##1 hreadyout) else $error("command wait wrong");
  chk_file_wait: assert property (tk && !hwrite && a[11:9] == 3'h1
    |=> !hreadyout ##1 hreadyout) else $error("file read wait wrong");
  chk_reg_nowait: assert property (tk && a[11:9] == 3'h0 && a != 12'h0
    |=> hreadyout) else $error("register access waited");
  chk_cmd_rdzero: assert property (tk && !hwrite && a == OFF_CMD
    |=> hrdata == 32'h0) else $error("command read not zero");

  ////////////////////////////////////////////////////////////////////////////
  // directions move only after an execute cycle; work moves only after a cycle without a wait
  chk_dir_a_moment: assert property ($changed(port_a_direction)
    |-> $past(hreadyout) && !$past(hreadyout, 2)) else $error("dir a moved");
  chk_dir_b_moment: assert property ($changed(port_b_direction)
    |-> $past(hreadyout) && !$past(hreadyout, 2)) else $error("dir b moved");
  chk_dir_c_moment: assert property ($changed(port_c_direction)
    |-> $past(hreadyout) && !$past(hreadyout, 2)) else $error("dir c moved");
  chk_dir_single: assert property ($onehot0({$changed(port_a_direction),
    $changed(port_b_direction), $changed(port_c_direction)}))
    else $error("two directions loaded");
  chk_work_moment: assert property ($changed(work_reg) |-> $past(hreadyout))
    else $error("work moved in a wait");
endmodule

bind byte_alu_instruction_subset alu_bus_monitor mon_u (.hclk, .hresetn,
  .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp,
  .port_a_direction, .port_b_direction, .port_c_direction, .work_reg);

//--- verification/tb_top.sv
// Purpose: self-checking bench for the byte alu instruction subset
// Assumes: bench is the only ahb-lite master
// Notes:   results are checked one step after the execute edge
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import byte_alu_pkg::*;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
  logic [1:0]  htrans = 2'h0, hresp;
  logic [2:0]  hsize = 3'h2;
  logic        hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
  logic        hready, hreadyout, carry_flag, nibble_carry_flag, zero_flag;
  logic [7:0]  port_a_direction, port_b_direction, port_c_direction, work_reg;
  int          fails = 0, n_tests = 0, cyc = 0;
  assign hready = hreadyout;
  always #2 hclk = ~hclk;
  byte_alu_instruction_subset dut_u (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
    .port_a_direction, .port_b_direction, .port_c_direction, .work_reg,
    .carry_flag, .nibble_carry_flag, .zero_flag);

  ////////////////////////////////////////////////////////////////////////////
  // report, compare and bus tasks
  task complete_run;
    $display("mismatches %0d comparisons %0d", fails, n_tests);
    if (fails == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task check(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task flg(input logic [2:0] e);
    check("flags", {29'h0, e},
          {29'h0, zero_flag, nibble_carry_flag, carry_flag});
  endtask
  task xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'h1;
    haddr <= {20'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'h1) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'h1) @(posedge hclk);
    q = hrdata;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    xfer(a, 1'h1, d);
  endtask
  task rdc(input logic [11:0] a, input string n, input logic [31:0] e);
    xfer(a, 1'h0, 32'h0);
    check(n, e, q);
  endtask
  task cmd(input logic [2:0] op, input logic [6:0] f, input logic d,
           input logic [7:0] k);
    xfer(OFF_CMD, 1'h1, {13'h0, op, d, f, k});
    #1;
  endtask
  function automatic logic [11:0] fa(input logic [6:0] f);
    return OFF_FILE + {3'h0, f, 2'h0};
  endfunction
  function automatic logic [31:0] w32();
    return {24'h0, work_reg};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task t_sub;
    wr(fa(7'h03), 32'h10);
    wr(OFF_WORK, 32'h01);
    wr(OFF_STATUS, 32'h0);
    cmd(OP_SUB_BORROW, 7'h03, 1'h0, 8'h00);
    check("sub w", 32'h0E, w32());
    flg(3'h1);
    wr(fa(7'h7F), 32'h05);
    wr(OFF_WORK, 32'hFFFF_FF05);
    rdc(OFF_WORK, "work read", 32'h05);
    wr(OFF_STATUS, 32'h1);
    cmd(OP_SUB_BORROW, 7'h7F, 1'h1, 8'h00);
    flg(3'h7);
    check("sub keep w", 32'h05, w32());
    rdc(fa(7'h7F), "sub file", 32'h0);
    cmd(OP_SUB_BORROW, 7'h7F, 1'h0, 8'h00);
    check("sub borrow", 32'hFB, w32());
    flg(3'h0);
  endtask
  task t_swap;
    wr(fa(7'h09), 32'hA5);
    wr(OFF_STATUS, 32'h7);
    cmd(OP_NIB_SWAP, 7'h09, 1'h0, 8'h00);
    check("swap w", 32'h5A, w32());
    flg(3'h7);
    wr(OFF_STATUS, 32'h0);
    cmd(OP_NIB_SWAP, 7'h09, 1'h1, 8'h00);
    flg(3'h0);
    check("swap keep w", 32'h5A, w32());
    rdc(fa(7'h09), "swap f", 32'h5A);
  endtask
  task t_xor;
    wr(OFF_STATUS, 32'h3);
    cmd(OP_XOR_IMM, 7'h00, 1'h0, 8'h5A);
    check("xori zero", 32'h00, w32());
    flg(3'h7);
    cmd(OP_XOR_IMM, 7'h09, 1'h1, 8'hFF);
    check("xori w", 32'hFF, w32());
    flg(3'h3);
    rdc(fa(7'h09), "xori file", 32'h5A);
    wr(fa(7'h00), 32'hF0);
    wr(OFF_WORK, 32'h0F);
    cmd(OP_XOR_FILE, 7'h00, 1'h1, 8'h00);
    rdc(fa(7'h00), "xorf file", 32'hFF);
    flg(3'h3);
    wr(OFF_WORK, 32'hFF);
    cmd(OP_XOR_FILE, 7'h00, 1'h0, 8'h00);
    check("xorf w", 32'h00, w32());
    flg(3'h7);
  endtask
  task t_dir;
    for (int i = 5; i <= 7; i++) begin
      wr(OFF_WORK, 32'h11 * i);
      cmd(OP_DIR_LOAD, i[6:0], 1'h0, 8'h00);
    end
    check("dirs", 32'h556677, {8'h0, port_a_direction, port_b_direction,
          port_c_direction});
    flg(3'h7);
    wr(OFF_WORK, 32'h99);
    cmd(OP_DIR_LOAD, 7'h04, 1'h0, 8'h00);
    rdc(OFF_STATUS, "refuse 4", 32'h0F);
    wr(OFF_STATUS, 32'h8);
    cmd(OP_DIR_LOAD, 7'h08, 1'h0, 8'h00);
    rdc(OFF_STATUS, "refuse 8", 32'h08);
    wr(OFF_STATUS, 32'h8);
    cmd(3'h5, 7'h05, 1'h0, 8'h00);
    rdc(OFF_STATUS, "bad op", 32'h08);
    check("dirs kept", 32'h556677, {8'h0, port_a_direction,
          port_b_direction, port_c_direction});
    wr(OFF_DIR_A, 32'h0);
    rdc(OFF_DIR_A, "dir a ro", 32'h55);
    rdc(OFF_DIR_C, "dir c rd", 32'h77);
    rdc(12'h100, "unmapped", 32'h0);
    rdc(OFF_CMD, "cmd read", 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // timeout and main sequence
  always @(posedge hclk) begin
    cyc++;
    if (cyc > 5000) begin
      fails++;
      complete_run;
    end
  end
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    check("reset", {DIR_RESET, DIR_RESET, DIR_RESET, WORK_RESET},
          {port_a_direction, port_b_direction, port_c_direction, work_reg});
    check("hresp", 32'h0, {30'h0, hresp});
    flg(3'h0);
    t_sub;
    t_swap;
    t_xor;
    t_dir;
    complete_run;
  end
endmodule
